// ==== core/ddsl_pkg.sv ====
// package: constants for the dual converter serial load logic
package ddsl_pkg;
   localparam int DDSL_RES_12 = 12;
   localparam int DDSL_RES_10 = 10;
   localparam int DDSL_CODE_W = DDSL_RES_12;
   localparam int DDSL_STEPS_12 = 4096;
   localparam int DDSL_STEPS_10 = 1024;
   localparam int DDSL_SYNC_STAGES = 2;
   localparam logic [11:0] DDSL_ZERO_12 = 12'h000;
   localparam logic [11:0] DDSL_HALF_12 = 12'h800;
   localparam logic [11:0] DDSL_HALF_10 = 12'h200;
   localparam logic [1:0] DDSL_SYNC_RST = 2'h0;
   typedef enum logic [1:0] {
      DDSL_HOLD_LATCHED = 2'b00,
      DDSL_HOLD_TRANSP = 2'b01,
      DDSL_HOLD_PRESET = 2'b10
   } ddsl_hold_t;
endpackage

// ==== core/ddsl_sync.sv ====
// two-stage level synchroniser into the core clock domain
`timescale 1ns/100ps
module ddsl_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

// ==== core/ddsl_core.sv ====
// dual converter serial shift and hold register logic
`timescale 1ns/100ps
module ddsl_core
   import ddsl_pkg::*;
#(
   parameter int RES = DDSL_RES_12
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic link_clk_i,
   input wire logic link_rst_i,
   input wire logic unit_select_n_i,
   input wire logic serial_in_i,
   input wire logic load_strobe_a_n_i,
   input wire logic load_strobe_b_n_i,
   input wire logic register_preset_n_i,
   input wire logic preset_half_i,
   input wire logic power_down_n_i,
   output logic [RES-1:0] hold_a_o,
   output logic [RES-1:0] hold_b_o,
   output logic [RES-1:0] shift_o,
   output logic active_o
);
   // ==========================================================
   // link domain: shift register on the serial clock
   // ==========================================================
   logic [RES-1:0] shift_reg;
   logic [RES-1:0] shift_next;
   logic [1:0] preset_l_reg;
   logic [1:0] sel_l_reg;

   function automatic logic [RES-1:0] ddsl_preset_val(input logic half);
      logic [RES-1:0] v;
      v = '0;
      v[RES-1] = half;
      return v;
   endfunction

   // select and preset sampled on the link clock before use
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         preset_l_reg <= DDSL_SYNC_RST;
         sel_l_reg <= 2'h3;
      end else begin
         preset_l_reg <= {preset_l_reg[0], ~register_preset_n_i};
         sel_l_reg <= {sel_l_reg[0], unit_select_n_i};
      end
   end

   always_comb begin
      shift_next = {shift_reg[RES-2:0], serial_in_i};
   end

   // shutdown does not gate shifting, contents persist
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         shift_reg <= '0;
      end else if (!sel_l_reg[1] && !preset_l_reg[1]) begin
         shift_reg <= shift_next;
      end
   end

   // ==========================================================
   // crossing into core domain
   // ==========================================================
   // word goes across as a level; host keeps it stable while loading
   logic [RES-1:0] shift_sync;
   logic [2:0] ctl_sync;

   ddsl_sync #(.W(RES)) u_shift_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .d_i(shift_reg),
      .q_o(shift_sync)
   );

   ddsl_sync #(.W(3)) u_ctl_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .d_i({~load_strobe_a_n_i, ~load_strobe_b_n_i, ~register_preset_n_i}),
      .q_o(ctl_sync)
   );

   logic half_s1_reg;
   logic half_reg;
   logic pdn_s1_reg;
   logic pdn_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         half_s1_reg <= 1'b0;
         half_reg <= 1'b0;
         pdn_s1_reg <= 1'b1;
         pdn_reg <= 1'b1;
      end else begin
         half_s1_reg <= preset_half_i;
         half_reg <= half_s1_reg;
         pdn_s1_reg <= power_down_n_i;
         pdn_reg <= pdn_s1_reg;
      end
   end

   // ==========================================================
   // core domain: hold registers
   // ==========================================================
   ddsl_hold_t mode_a;
   ddsl_hold_t mode_b;

   function automatic ddsl_hold_t ddsl_mode(input logic preset, input logic load);
      if (preset) begin
         return DDSL_HOLD_PRESET;
      end else if (load) begin
         return DDSL_HOLD_TRANSP;
      end else begin
         return DDSL_HOLD_LATCHED;
      end
   endfunction

   always_comb begin
      mode_a = ddsl_mode(ctl_sync[0], ctl_sync[2]);
      mode_b = ddsl_mode(ctl_sync[0], ctl_sync[1]);
   end

   // select is not looked at here; strobes act regardless
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hold_a_o <= '0;
      end else begin
         case (mode_a)
            DDSL_HOLD_PRESET: hold_a_o <= ddsl_preset_val(half_reg);
            DDSL_HOLD_TRANSP: hold_a_o <= shift_sync;
            default: hold_a_o <= hold_a_o;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hold_b_o <= '0;
      end else begin
         case (mode_b)
            DDSL_HOLD_PRESET: hold_b_o <= ddsl_preset_val(half_reg);
            DDSL_HOLD_TRANSP: hold_b_o <= shift_sync;
            default: hold_b_o <= hold_b_o;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         shift_o <= '0;
         active_o <= 1'b1;
      end else begin
         shift_o <= shift_sync;
         active_o <= pdn_reg;
      end
   end

   // ==========================================================
   // checks: core domain
   // ==========================================================
   preset_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ctl_sync[0] |=> hold_a_o == ddsl_preset_val($past(half_reg)))
      else $error("hold a not preset");
   preset_hold_b_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ctl_sync[0] |=> hold_b_o == ddsl_preset_val($past(half_reg)))
      else $error("hold b not preset");
   load_copy_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (!ctl_sync[0] && ctl_sync[2]) |=> hold_a_o == $past(shift_sync))
      else $error("hold a not loaded");
   load_copy_b_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (!ctl_sync[0] && ctl_sync[1]) |=> hold_b_o == $past(shift_sync))
      else $error("hold b not loaded");
   latched_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (!ctl_sync[0] && !ctl_sync[2] && !ctl_sync[1]) |=> $stable(hold_a_o) && $stable(hold_b_o))
      else $error("hold changed while latched");
   wake_state_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(active_o) |-> $stable(hold_a_o) || $past(ctl_sync[2] || ctl_sync[0]))
      else $error("hold changed on wake");
   // shutdown reaches the activity flag and nothing else
   power_track_a: assert property (@(posedge clk_i) disable iff (srst_i)
      active_o == $past(pdn_reg))
      else $error("activity flag does not follow shutdown");
   // the visible shift copy is one flop behind the synchroniser
   shift_copy_a: assert property (@(posedge clk_i) disable iff (srst_i)
      shift_o == $past(shift_sync))
      else $error("shift copy out of step");

   // ==========================================================
   // checks: link domain
   // ==========================================================
   shift_step_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
      (!sel_l_reg[1] && !preset_l_reg[1]) |=>
      shift_reg == {$past(shift_reg[RES-2:0]), $past(serial_in_i)})
      else $error("shift did not advance");
   select_hold_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
      sel_l_reg[1] |=> $stable(shift_reg))
      else $error("shift moved while deselected");
   // a preset also freezes the shift register, by choice
   preset_freeze_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
      preset_l_reg[1] |=> $stable(shift_reg))
      else $error("shift moved during preset");
endmodule

// ==== verification/ddsl_host_model.sv ====
// host model: serial clock, select and serial data
`timescale 1ns/100ps
module ddsl_host_model (
   output logic link_clk_o,
   output logic link_rst_o,
   output logic sel_n_o,
   output logic sdi_o
);
   // ====
   // link clock stands still outside frames and link reset
   initial begin
      link_clk_o = 1'b0;
      link_rst_o = 1'b1;
      sel_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   task automatic tick();
      #15 link_clk_o = 1'b1;
      #15 link_clk_o = 1'b0;
   endtask
   task automatic link_reset();
      repeat (4) tick();
      link_rst_o = 1'b0;
   endtask
   // lead-in ones cover the select flops; they leave through the top
   task automatic send(input logic [11:0] w, input logic sel_n);
      sel_n_o = sel_n;
      sdi_o = 1'b1;
      repeat (3) tick();
      for (int i = 11; i >= 0; i--) begin
         sdi_o = w[i];
         tick();
      end
      sel_n_o = 1'b1;
      sdi_o = ~sdi_o;
   endtask
endmodule

// ==== verification/dual_dac_serial_load_logic_tb_top.sv ====
// bench for the dual converter serial load logic
`timescale 1ns/100ps
module dual_dac_serial_load_logic_tb_top;
   import ddsl_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ld_a_n = 1'b1;
   logic ld_b_n = 1'b1;
   logic pre_n = 1'b1;
   logic half = 1'b0;
   logic pd_n = 1'b1;
   logic lclk, lrst, sel_n, serial_in, act;
   logic [11:0] ha, hb, sh;
   logic [9:0] ha10, hb10, sh10;
   logic act10;
   int miscompares = 0;
   int comparisons = 0;
   always #4 clk_i = ~clk_i;
   ddsl_host_model host_u (.link_clk_o(lclk), .link_rst_o(lrst), .sel_n_o(sel_n), .sdi_o(serial_in));
   ddsl_core #(.RES(12)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .link_clk_i(lclk),
      .link_rst_i(lrst), .unit_select_n_i(sel_n), .serial_in_i(serial_in),
      .load_strobe_a_n_i(ld_a_n), .load_strobe_b_n_i(ld_b_n),
      .register_preset_n_i(pre_n), .preset_half_i(half), .power_down_n_i(pd_n),
      .hold_a_o(ha), .hold_b_o(hb), .shift_o(sh), .active_o(act));
   // ten-bit variant on the same pins; extra bits fall out of its top
   ddsl_core #(.RES(10)) dut10_u (.clk_i(clk_i), .srst_i(srst_i), .link_clk_i(lclk),
      .link_rst_i(lrst), .unit_select_n_i(sel_n), .serial_in_i(serial_in),
      .load_strobe_a_n_i(ld_a_n), .load_strobe_b_n_i(ld_b_n),
      .register_preset_n_i(pre_n), .preset_half_i(half), .power_down_n_i(pd_n),
      .hold_a_o(ha10), .hold_b_o(hb10), .shift_o(sh10), .active_o(act10));
   // ====
   // shared tasks
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // link clock is idle whenever a strobe is low
   task automatic strobe(input logic b);
      if (b) ld_b_n = 1'b0;
      else ld_a_n = 1'b0;
      cyc(5);
      ld_a_n = 1'b1;
      ld_b_n = 1'b1;
      cyc(5);
   endtask
   task automatic put(input logic [11:0] w, input logic s);
      host_u.send(w, s);
      cyc(6);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ====
   // scenarios
   task automatic t_load();
      put(12'hA5C, 1'b0);
      check(sh, 12'hA5C);
      check({2'h0, sh10}, 12'h25C);
      strobe(1'b0);
      check(ha, 12'hA5C);
      check({2'h0, ha10}, 12'h25C);
      check(hb, DDSL_ZERO_12);
      put(12'h3F1, 1'b0);
      strobe(1'b1);
      check(hb, 12'h3F1);
      check({2'h0, hb10}, 12'h3F1);
      check(ha, 12'hA5C);
      $display("test load done");
   endtask
   // all-ones word makes stray lead-in shifts harmless
   task automatic t_select();
      put(12'hFFF, 1'b0);
      put(12'h000, 1'b1);
      check(sh, 12'hFFF);
      strobe(1'b0);
      check(ha, 12'hFFF);
      $display("test select done");
   endtask
   task automatic t_preset();
      half = 1'b1;
      pre_n = 1'b0;
      cyc(5);
      check(ha, DDSL_HALF_12);
      check(hb, DDSL_HALF_12);
      check({2'h0, ha10}, DDSL_HALF_10);
      half = 1'b0;
      cyc(5);
      check(ha, DDSL_ZERO_12);
      check(hb, DDSL_ZERO_12);
      pre_n = 1'b1;
      cyc(5);
      $display("test preset done");
   endtask
   task automatic t_down();
      pd_n = 1'b0;
      cyc(5);
      check({11'h000, act}, 12'h000);
      check(hb, DDSL_ZERO_12);
      put(12'h123, 1'b0);
      strobe(1'b0);
      check(ha, 12'h123);
      pd_n = 1'b1;
      cyc(5);
      check({11'h000, act}, 12'h001);
      check({11'h000, act10}, 12'h001);
      check(ha, 12'h123);
      $display("test shutdown done");
   endtask
   initial begin
      host_u.link_reset();
      cyc(10);
      srst_i = 1'b0;
      cyc(3);
      t_load();
      t_select();
      t_preset();
      t_down();
      print_verdict();
   end
   // cuts a hang short
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
endmodule
